// file: mem_side_model.sv
// Memory-side partner: instruction cache responder and table memory
`default_nettype none

module mem_side_model #(
	parameter int GNT_WAIT = 2,
	parameter logic [21:0] ROOT = 22'h100
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic icache_req,
	output logic icache_gnt,
	output logic icache_rvalid,
	input wire logic walk_req,
	input wire logic [mmu_pkg::PA_W-1:0] walk_addr,
	output logic walk_gnt,
	output logic walk_rvalid,
	output logic [mmu_pkg::PTE_W-1:0] walk_rdata,
	output logic [15:0] read_cnt,
	output logic [mmu_pkg::PA_W-1:0] root_addr
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] wait_reg;
	logic pend_reg;
	logic [mmu_pkg::PA_W-1:0] addr_reg;

	// ------------------------------------------------------------
	// Table contents: root pointer, then leaves with X, without X, invalid
	// ------------------------------------------------------------
	function automatic logic [31:0] entry(input logic [33:0] a);
		if (a[33:12] == ROOT) begin
			return {22'h101, 10'h001};
		end
		if (a[33:12] == 22'h101) begin
			case (a[11:2])
				10'h000: return {22'h200, 10'h00F};
				10'h001: return {22'h201, 10'h003};
				default: return 32'h0;
			endcase
		end
		return 32'h0;
	endfunction

	// Cache grants at once, answers one cycle later, in order
	assign icache_gnt = icache_req;
	// Table reads are granted only after a deliberate wait
	assign walk_gnt = walk_req && (wait_reg == GNT_WAIT[3:0]);

	// One read outstanding; idle data line inverts its own value every cycle
	always_ff @(posedge clk) begin
		if (srst) begin
			icache_rvalid <= 1'b0;
			wait_reg <= 4'h0;
			pend_reg <= 1'b0;
			walk_rvalid <= 1'b0;
			walk_rdata <= 32'h0;
			read_cnt <= 16'h0;
			root_addr <= 34'h0;
			addr_reg <= 34'h0;
		end else begin
			icache_rvalid <= icache_req;
			wait_reg <= (walk_req && !walk_gnt) ? wait_reg + 4'h1 : 4'h0;
			pend_reg <= walk_gnt;
			walk_rvalid <= pend_reg;
			walk_rdata <= pend_reg ? entry(addr_reg) : ~walk_rdata;
			if (walk_gnt) begin
				addr_reg <= walk_addr;
				read_cnt <= read_cnt + 16'h1;
				if (walk_addr[33:12] == ROOT) begin
					root_addr <= walk_addr;
				end
			end
		end
	end
endmodule

`default_nettype wire

// file: mmu_pkg.sv
// Shared constants for the address translation unit
`default_nettype none

package mmu_pkg;
	// ------------------------------------------------------------
	// Address geometry
	// ------------------------------------------------------------
	localparam int VA_W = 32;
	localparam int PA_W = 34;
	localparam int VPN_W = 20;
	localparam int VPN_PART_W = 10;
	localparam int PPN_W = 22;
	localparam int OFS_W = 12;
	localparam int PTE_W = 32;
	// ------------------------------------------------------------
	// Table entry fields
	// ------------------------------------------------------------
	localparam int PTE_V = 0;
	localparam int PTE_R = 1;
	localparam int PTE_W_BIT = 2;
	localparam int PTE_X = 3;
	localparam int PTE_U = 4;
	localparam int PTE_PPN_LSB = 10;
	// Permission vector order: {user, exec, write, read}
	localparam int PERM_R = 0;
	localparam int PERM_W = 1;
	localparam int PERM_X = 2;
	localparam int PERM_U = 3;
	localparam int PERM_N = 4;
	// ------------------------------------------------------------
	// Protection granularity G=8: regions of 2^(G+2) bytes
	// ------------------------------------------------------------
	localparam int PROT_G = 8;
	localparam int PROT_SHIFT = PROT_G + 2;
	// Executable physical range for the attribute check, inclusive
	localparam logic [PA_W-1:0] EXEC_BASE = 34'h0_0000_0000;
	localparam logic [PA_W-1:0] EXEC_LAST = 34'h3_FFFF_FFFF;
	// Walk levels: top level at walk start, leaf level after descent
	localparam logic [1:0] LEVEL_TOP = 2'h1;
	localparam logic [1:0] LEVEL_RST = 2'h0;
endpackage

`default_nettype wire

// file: mmu_translation_unit.sv
// Address translation unit for instruction fetch and load/store
`default_nettype none

// Function
// - Translate and report page faults only when enabled and below machine privilege.
// - Translation off passes fetch virtual address straight to instruction cache.
// - Translation on holds cache request until valid translation; else exception.
// - Instruction buffer hit resolves combinationally, no register stage.
// - Both buffers fully associative flip-flops, sized by parameter; id width configurable.
// - Fetch exception returned with response valid, not with grant.
// - Fetch exceptions queued in order and returned with their response.
// - Data translation is handshaked; buffer hit answers one cycle later.
// - Excepting load or store never completes a memory access.
// - Separate buffers for fetch and data; only walker is shared.
// - Walker watches both buffers, captures missing address, starts walk.
// - Walker error raises page fault to the requester that caused it.
// - Data buffer miss is served before an instruction miss.
// - Fetch walk multi-cycle refills buffer; hit recheck each cycle ends it.
// - Protection checks apply with translation off and on.
// - Attribute checks only on final fetch physical access, not data accesses or table reads.
// - Every walker memory read passes protection rules.
// - Protection entry count is a parameter; only granularity 8 supported.
// - Three checkers: fetch, data, and walker accesses.
// - Address space id never exempts entries from flushing.
module mmu_translation_unit #(
	parameter int INSTR_TRANSLATION_BUFFER_ENTRIES = 16,
	parameter int DATA_TRANSLATION_BUFFER_ENTRIES = 16,
	parameter int ADDRESS_SPACE_ID_W = 9,
	parameter int PROTECTION_ENTRY_COUNT = 8,
	parameter int FEX_DEPTH = 4
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic flush_tlb,
	input wire logic translation_en,
	input wire logic machine_mode,
	input wire logic user_mode,
	input wire logic [mmu_pkg::PPN_W-1:0] root_ppn,
	input wire logic [ADDRESS_SPACE_ID_W-1:0] address_space_id,
	input wire logic [PROTECTION_ENTRY_COUNT*mmu_pkg::PA_W-1:0] prot_base,
	input wire logic [PROTECTION_ENTRY_COUNT*mmu_pkg::PA_W-1:0] prot_top,
	input wire logic [PROTECTION_ENTRY_COUNT*3-1:0] prot_perm,
	input wire logic fetch_req,
	input wire logic [mmu_pkg::VA_W-1:0] fetch_vaddr,
	output logic fetch_gnt,
	output logic fetch_rvalid,
	output logic fetch_ex,
	output logic icache_req,
	output logic [mmu_pkg::PA_W-1:0] icache_paddr,
	input wire logic icache_gnt,
	input wire logic icache_rvalid,
	input wire logic lsu_req,
	input wire logic lsu_store,
	input wire logic [mmu_pkg::VA_W-1:0] lsu_vaddr,
	output logic lsu_ready,
	output logic lsu_rsp_valid,
	output logic [mmu_pkg::PA_W-1:0] lsu_paddr,
	output logic lsu_ex,
	output logic walk_req,
	output logic [mmu_pkg::PA_W-1:0] walk_addr,
	input wire logic walk_gnt,
	input wire logic walk_rvalid,
	input wire logic [mmu_pkg::PTE_W-1:0] walk_rdata
);
	localparam int FP_W = (FEX_DEPTH > 1) ? $clog2(FEX_DEPTH) : 1;
	localparam int PN = mmu_pkg::PERM_N;

	typedef enum logic [1:0] {W_IDLE, W_REQ, W_WAIT} walk_state_t;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Page permission: needed access present, user pages for user mode
	function automatic logic perm_ok(input logic [PN-1:0] p, input logic [2:0] need,
		input logic usr);
		perm_ok = ((p[2:0] & need) == need) && (!usr || p[mmu_pkg::PERM_U]);
	endfunction

	// Compose physical address from page number and page offset
	function automatic logic [mmu_pkg::PA_W-1:0] phys(input logic [mmu_pkg::PPN_W-1:0] ppn,
		input logic [mmu_pkg::VA_W-1:0] va);
		phys = {ppn, va[mmu_pkg::OFS_W-1:0]};
	endfunction

	walk_state_t state_reg;
	logic walk_data_reg;
	logic level_reg;
	logic [mmu_pkg::VA_W-1:0] wva_reg;
	logic [mmu_pkg::PA_W-1:0] walk_addr_reg;
	logic ifault_reg;
	logic dfault_reg;
	logic [FEX_DEPTH-1:0] fex_reg;
	logic [FP_W-1:0] frd_reg;
	logic [FP_W-1:0] fwr_reg;
	logic [FP_W:0] fcnt_reg;
	logic rsp_valid_reg;
	logic rsp_ex_reg;
	logic [mmu_pkg::PA_W-1:0] rsp_pa_reg;

	// ------------------------------------------------------------
	// Translation enable and buffers
	// ------------------------------------------------------------
	wire trans_act = translation_en && !machine_mode;
	wire ihit;
	wire dhit;
	wire [mmu_pkg::PPN_W-1:0] ippn;
	wire [mmu_pkg::PPN_W-1:0] dppn;
	wire [PN-1:0] iperm;
	wire [PN-1:0] dperm;
	wire leaf_we;
	wire [mmu_pkg::PPN_W-1:0] pte_ppn = walk_rdata[mmu_pkg::PTE_PPN_LSB +: mmu_pkg::PPN_W];
	wire [mmu_pkg::PPN_W-1:0] fill_ppn = level_reg
		? {pte_ppn[mmu_pkg::PPN_W-1:mmu_pkg::VPN_PART_W],
		wva_reg[mmu_pkg::OFS_W +: mmu_pkg::VPN_PART_W]} : pte_ppn;
	wire [PN-1:0] fill_perm = {walk_rdata[mmu_pkg::PTE_U], walk_rdata[mmu_pkg::PTE_X],
		walk_rdata[mmu_pkg::PTE_W_BIT], walk_rdata[mmu_pkg::PTE_R]};

	// Separate fetch and data buffers, refilled only by the walker
	tlb_store #(.ENTRIES(INSTR_TRANSLATION_BUFFER_ENTRIES), .ADDRESS_SPACE_ID_W(ADDRESS_SPACE_ID_W)) instr_translation_buffer (
		.clk(clk),
		.srst(srst),
		.flush(flush_tlb),
		.lk_vpn(fetch_vaddr[mmu_pkg::VA_W-1:mmu_pkg::OFS_W]),
		.lk_address_space_id(address_space_id),
		.hit(ihit),
		.hit_ppn(ippn),
		.hit_perm(iperm),
		.we(leaf_we && !walk_data_reg),
		.w_vpn(wva_reg[mmu_pkg::VA_W-1:mmu_pkg::OFS_W]),
		.w_super(level_reg),
		.w_ppn(fill_ppn),
		.w_perm(fill_perm),
		.w_address_space_id(address_space_id)
	);

	tlb_store #(.ENTRIES(DATA_TRANSLATION_BUFFER_ENTRIES), .ADDRESS_SPACE_ID_W(ADDRESS_SPACE_ID_W)) data_translation_buffer (
		.clk(clk),
		.srst(srst),
		.flush(flush_tlb),
		.lk_vpn(lsu_vaddr[mmu_pkg::VA_W-1:mmu_pkg::OFS_W]),
		.lk_address_space_id(address_space_id),
		.hit(dhit),
		.hit_ppn(dppn),
		.hit_perm(dperm),
		.we(leaf_we && walk_data_reg),
		.w_vpn(wva_reg[mmu_pkg::VA_W-1:mmu_pkg::OFS_W]),
		.w_super(level_reg),
		.w_ppn(fill_ppn),
		.w_perm(fill_perm),
		.w_address_space_id(address_space_id)
	);

	// ------------------------------------------------------------
	// Fetch path
	// ------------------------------------------------------------
	wire [mmu_pkg::PA_W-1:0] i_pa = trans_act ? phys(ippn, fetch_vaddr)
		: mmu_pkg::PA_W'(fetch_vaddr);
	wire i_known = !trans_act || ihit;
	wire i_prot_ok;
	wire i_attr_ok = i_pa >= mmu_pkg::EXEC_BASE && i_pa <= mmu_pkg::EXEC_LAST;
	wire i_page_ok = !trans_act || perm_ok(iperm, 3'h4, user_mode);
	wire i_fault = fetch_req && (ifault_reg || (i_known && !(i_page_ok && i_prot_ok && i_attr_ok)));
	wire fex_full = fcnt_reg == (FP_W + 1)'(FEX_DEPTH);
	wire fex_empty = fcnt_reg == '0;
	wire i_go = fetch_req && i_known && !i_fault && !fex_full;
	wire i_fault_take = i_fault && fex_empty;
	wire fex_push = (i_go && icache_gnt) || i_fault_take;
	wire head_ex = fex_reg[frd_reg];
	wire fex_pop = !fex_empty && (head_ex || icache_rvalid);
	wire i_miss = fetch_req && trans_act && !ihit && !ifault_reg;

	// Fetch checker: execute access
	prot_check #(.ENTRIES(PROTECTION_ENTRY_COUNT)) fetch_prot (
		.addr(i_pa),
		.acc(3'h4),
		.machine(machine_mode),
		.base(prot_base),
		.top(prot_top),
		.perm(prot_perm),
		.ok(i_prot_ok)
	);

	// Combinational fetch handshake; faults answer with response valid
	assign icache_req = i_go;
	assign icache_paddr = i_pa;
	assign fetch_gnt = fex_push;
	assign fetch_rvalid = fex_pop;
	assign fetch_ex = !fex_empty && head_ex;

	// Exception queue: one flag per outstanding fetch, in order
	always_ff @(posedge clk) begin
		if (srst) begin
			frd_reg <= '0;
			fwr_reg <= '0;
			fcnt_reg <= '0;
			fex_reg <= '0;
		end else begin
			if (fex_push) begin
				fex_reg[fwr_reg] <= i_fault_take;
				fwr_reg <= (fwr_reg == FP_W'(FEX_DEPTH - 1)) ? '0 : fwr_reg + 1'b1;
			end
			if (fex_pop) begin
				frd_reg <= (frd_reg == FP_W'(FEX_DEPTH - 1)) ? '0 : frd_reg + 1'b1;
			end
			fcnt_reg <= fcnt_reg + (FP_W + 1)'(fex_push) - (FP_W + 1)'(fex_pop);
		end
	end

	// ------------------------------------------------------------
	// Data path
	// ------------------------------------------------------------
	wire [mmu_pkg::PA_W-1:0] d_pa = trans_act ? phys(dppn, lsu_vaddr)
		: mmu_pkg::PA_W'(lsu_vaddr);
	wire d_prot_ok;
	wire [2:0] d_need = lsu_store ? 3'h2 : 3'h1;
	wire d_page_ok = !trans_act || perm_ok(dperm, d_need, user_mode);
	wire d_take = lsu_req && (!trans_act || dhit || dfault_reg);
	wire d_bad = dfault_reg || !d_page_ok || !d_prot_ok;
	wire d_miss = lsu_req && trans_act && !dhit && !dfault_reg;

	// Data checker: load or store access
	prot_check #(.ENTRIES(PROTECTION_ENTRY_COUNT)) data_prot (
		.addr(d_pa),
		.acc(d_need),
		.machine(machine_mode),
		.base(prot_base),
		.top(prot_top),
		.perm(prot_perm),
		.ok(d_prot_ok)
	);

	// Handshake and registered answer one cycle after acceptance
	assign lsu_ready = d_take;
	assign lsu_rsp_valid = rsp_valid_reg;
	assign lsu_paddr = rsp_pa_reg;
	assign lsu_ex = rsp_ex_reg;

	// Answer register bank
	always_ff @(posedge clk) begin
		if (srst) begin
			rsp_valid_reg <= 1'b0;
			rsp_ex_reg <= 1'b0;
			rsp_pa_reg <= '0;
		end else begin
			rsp_valid_reg <= d_take;
			rsp_ex_reg <= d_take && d_bad;
			rsp_pa_reg <= d_pa;
		end
	end

	// ------------------------------------------------------------
	// Shared table walker
	// ------------------------------------------------------------
	wire w_prot_ok;
	wire pte_v = walk_rdata[mmu_pkg::PTE_V];
	wire pte_leaf = walk_rdata[mmu_pkg::PTE_R] || walk_rdata[mmu_pkg::PTE_X];
	wire pte_bad = !pte_v || (!walk_rdata[mmu_pkg::PTE_R] && walk_rdata[mmu_pkg::PTE_W_BIT]);
	wire in_wait = state_reg == W_WAIT && walk_rvalid;
	assign leaf_we = in_wait && !pte_bad && pte_leaf && !flush_tlb;
	wire descend = in_wait && !pte_bad && !pte_leaf && level_reg;
	wire w_fault = (in_wait && !leaf_we && !descend)
		|| (state_reg == W_REQ && !w_prot_ok);
	wire start = state_reg == W_IDLE && (d_miss || i_miss);
	wire start_data = d_miss;
	wire [mmu_pkg::VA_W-1:0] start_va = start_data ? lsu_vaddr : fetch_vaddr;

	// Walker checker: reads of table entries
	prot_check #(.ENTRIES(PROTECTION_ENTRY_COUNT)) walk_prot (
		.addr(walk_addr_reg),
		.acc(3'h1),
		.machine(1'b0),
		.base(prot_base),
		.top(prot_top),
		.perm(prot_perm),
		.ok(w_prot_ok)
	);

	assign walk_req = state_reg == W_REQ && w_prot_ok;
	assign walk_addr = walk_addr_reg;

	// Walk sequencing: top level, then leaf level if pointed to
	always_ff @(posedge clk) begin
		if (srst || flush_tlb) begin
			state_reg <= W_IDLE;
		end else begin
			unique case (state_reg)
				W_IDLE: state_reg <= start ? W_REQ : W_IDLE;
				W_REQ: state_reg <= !w_prot_ok ? W_IDLE : (walk_gnt ? W_WAIT : W_REQ);
				W_WAIT: state_reg <= !walk_rvalid ? W_WAIT : (descend ? W_REQ : W_IDLE);
			endcase
		end
	end

	// Walk context: requester, level, captured address, entry address
	always_ff @(posedge clk) begin
		if (srst) begin
			walk_data_reg <= 1'b0;
			level_reg <= 1'b0;
			wva_reg <= '0;
			walk_addr_reg <= '0;
		end else if (start) begin
			walk_data_reg <= start_data;
			level_reg <= mmu_pkg::LEVEL_TOP[0];
			wva_reg <= start_va;
			walk_addr_reg <= {root_ppn, start_va[mmu_pkg::VA_W-1 -: mmu_pkg::VPN_PART_W], 2'h0};
		end else if (descend) begin
			level_reg <= mmu_pkg::LEVEL_RST[0];
			walk_addr_reg <= {pte_ppn, wva_reg[mmu_pkg::OFS_W +: mmu_pkg::VPN_PART_W], 2'h0};
		end
	end

	// Walk faults held for their requester; a new fault wins over a clear
	always_ff @(posedge clk) begin
		if (srst || flush_tlb) begin
			ifault_reg <= 1'b0;
			dfault_reg <= 1'b0;
		end else begin
			ifault_reg <= (w_fault && !walk_data_reg) || (ifault_reg && !i_fault_take);
			dfault_reg <= (w_fault && walk_data_reg) || (dfault_reg && !d_take);
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	bypass_addr_a: assert property (@(posedge clk) disable iff (srst)
		!trans_act && icache_req |-> icache_paddr == mmu_pkg::PA_W'(fetch_vaddr))
		else $error("fetch address altered with translation off");
	fetch_hold_a: assert property (@(posedge clk) disable iff (srst)
		trans_act && icache_req |-> ihit && !ifault_reg)
		else $error("fetch sent to cache without a translation");
	fex_with_valid_a: assert property (@(posedge clk) disable iff (srst)
		fetch_ex |-> fetch_rvalid)
		else $error("fetch exception without response valid");
	fex_queue_a: assert property (@(posedge clk) disable iff (srst)
		i_fault_take |=> fetch_rvalid && fetch_ex)
		else $error("queued fetch exception not returned next cycle");
	data_latency_a: assert property (@(posedge clk) disable iff (srst)
		lsu_req && lsu_ready && d_bad |=> lsu_rsp_valid && lsu_ex)
		else $error("data answer missing one cycle after acceptance");
	data_first_a: assert property (@(posedge clk) disable iff (srst || flush_tlb)
		state_reg == W_IDLE && d_miss && i_miss |=> walk_data_reg && state_reg == W_REQ)
		else $error("instruction miss served before data miss");
	walk_enable_a: assert property (@(posedge clk) disable iff (srst)
		state_reg == W_IDLE && !trans_act |=> state_reg == W_IDLE)
		else $error("walk started with translation disabled");
	walk_prot_a: assert property (@(posedge clk) disable iff (srst || flush_tlb)
		walk_req && !walk_gnt |=> walk_req && $stable(walk_addr_reg))
		else $error("checked table read dropped or moved before grant");
endmodule

`default_nettype wire

// file: mmu_translation_unit_tb.sv
// Self-checking testbench of the address translation unit
`default_nettype none

module mmu_translation_unit_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic flush_tlb = 1'b0;
	logic translation_en = 1'b1;
	logic machine_mode = 1'b1;
	logic user_mode = 1'b0;
	logic [8:0] address_space_id = 9'h000;
	logic fetch_req = 1'b0;
	logic [31:0] fetch_vaddr = 32'h0;
	logic lsu_req = 1'b0;
	logic lsu_store = 1'b0;
	logic [31:0] lsu_vaddr = 32'h0;
	logic fetch_gnt, fetch_rvalid, fetch_ex, icache_req, icache_gnt, icache_rvalid;
	logic lsu_ready, lsu_rsp_valid, lsu_ex, walk_req, walk_gnt, walk_rvalid;
	logic [33:0] icache_paddr, lsu_paddr, walk_addr, root_addr;
	logic [31:0] walk_rdata;
	logic [15:0] read_cnt;
	int error_cnt = 0;
	int checks_done = 0;

	// ------------------------------------------------------------
	// Clock, design and memory side
	// ------------------------------------------------------------
	always #2.5 clk = ~clk;

	mmu_translation_unit #(.INSTR_TRANSLATION_BUFFER_ENTRIES(4), .DATA_TRANSLATION_BUFFER_ENTRIES(4), .PROTECTION_ENTRY_COUNT(2))
	mmu_translation_unit_inst (.clk(clk), .srst(srst), .flush_tlb(flush_tlb),
		.translation_en(translation_en), .machine_mode(machine_mode), .user_mode(user_mode),
		.root_ppn(22'h100), .address_space_id(address_space_id),
		.prot_base({34'h0, 34'h0}), .prot_top({34'h0, 34'h1_0000_0000}),
		.prot_perm({3'h0, 3'h7}), .fetch_req(fetch_req), .fetch_vaddr(fetch_vaddr),
		.fetch_gnt(fetch_gnt), .fetch_rvalid(fetch_rvalid), .fetch_ex(fetch_ex),
		.icache_req(icache_req), .icache_paddr(icache_paddr), .icache_gnt(icache_gnt),
		.icache_rvalid(icache_rvalid), .lsu_req(lsu_req), .lsu_store(lsu_store),
		.lsu_vaddr(lsu_vaddr), .lsu_ready(lsu_ready), .lsu_rsp_valid(lsu_rsp_valid),
		.lsu_paddr(lsu_paddr), .lsu_ex(lsu_ex), .walk_req(walk_req), .walk_addr(walk_addr),
		.walk_gnt(walk_gnt), .walk_rvalid(walk_rvalid), .walk_rdata(walk_rdata));

	mem_side_model mem_side_model_inst (.clk(clk), .srst(srst), .icache_req(icache_req),
		.icache_gnt(icache_gnt), .icache_rvalid(icache_rvalid), .walk_req(walk_req),
		.walk_addr(walk_addr), .walk_gnt(walk_gnt), .walk_rvalid(walk_rvalid),
		.walk_rdata(walk_rdata), .read_cnt(read_cnt), .root_addr(root_addr));

	// ------------------------------------------------------------
	// Comparison and closing
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Fetch: hold request to grant, answer one cycle later; count new table reads
	task automatic fetch(input logic [31:0] va, input logic [33:0] pa, input logic ex,
		input logic [15:0] walks);
		int n;
		logic [15:0] r0;
		r0 = read_cnt;
		n = 0;
		@(negedge clk);
		fetch_req = 1'b1;
		fetch_vaddr = va;
		#1;
		while (fetch_gnt !== 1'b1 && n < 200) begin
			@(negedge clk);
			#1;
			n++;
		end
		check("fetch grant", {33'h0, fetch_gnt}, 34'h1);
		check("icache req", {33'h0, icache_req}, {33'h0, !ex});
		if (!ex) check("icache addr", icache_paddr, pa);
		@(negedge clk);
		fetch_req = 1'b0;
		#1;
		check("fetch rvalid", {33'h0, fetch_rvalid}, 34'h1);
		check("fetch ex", {33'h0, fetch_ex}, {33'h0, ex});
		check("fetch walks", {18'h0, read_cnt - r0}, {18'h0, walks});
	endtask

	// Data: hold request to ready, registered answer one cycle later
	task automatic data(input logic [31:0] va, input logic st, input logic [33:0] pa,
		input logic ex, input logic [15:0] walks);
		int n;
		logic [15:0] r0;
		r0 = read_cnt;
		n = 0;
		@(negedge clk);
		lsu_req = 1'b1;
		lsu_store = st;
		lsu_vaddr = va;
		#1;
		while (lsu_ready !== 1'b1 && n < 200) begin
			@(negedge clk);
			#1;
			n++;
		end
		@(negedge clk);
		lsu_req = 1'b0;
		#1;
		check("lsu rsp valid", {33'h0, lsu_rsp_valid}, 34'h1);
		check("lsu ex", {33'h0, lsu_ex}, {33'h0, ex});
		// As load unit, check the exception flag that would drop the cache access of a load
		check("load cancel", {33'h0, lsu_ex && !st}, {33'h0, ex && !st});
		if (!ex) check("lsu addr", lsu_paddr, pa);
		check("data walks", {18'h0, read_cnt - r0}, {18'h0, walks});
	endtask

	// Data and fetch miss together: the data walk goes first
	task automatic race();
		int n;
		logic [15:0] r0;
		r0 = read_cnt;
		n = 0;
		@(negedge clk);
		fetch_req = 1'b1;
		fetch_vaddr = 32'h0040_1000;
		lsu_req = 1'b1;
		lsu_store = 1'b0;
		lsu_vaddr = 32'h0040_0044;
		#1;
		while (lsu_ready !== 1'b1 && n < 200) begin
			@(negedge clk);
			#1;
			n++;
		end
		check("race fetch gnt", {33'h0, fetch_gnt}, 34'h0);
		check("race data walks", {18'h0, read_cnt - r0}, 34'h2);
		@(negedge clk);
		lsu_req = 1'b0;
		#1;
		check("race lsu valid", {33'h0, lsu_rsp_valid}, 34'h1);
		check("race lsu addr", lsu_paddr, 34'h0_0020_0044);
		while (fetch_gnt !== 1'b1 && n < 400) begin
			@(negedge clk);
			#1;
			n++;
		end
		check("race fetch walks", {18'h0, read_cnt - r0}, 34'h4);
		check("race icache req", {33'h0, icache_req}, 34'h0);
		@(negedge clk);
		fetch_req = 1'b0;
		#1;
		check("race fetch ex", {32'h0, fetch_rvalid, fetch_ex}, 34'h3);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (10) @(posedge clk);
		@(negedge clk);
		srst = 1'b0;
		// Machine privilege: enabled paging still passes addresses through
		fetch(32'h8000_1234, 34'h0_8000_1234, 1'b0, 16'h0);
		data(32'h8000_2008, 1'b1, 34'h0_8000_2008, 1'b0, 16'h0);
		machine_mode = 1'b0;
		// Miss walks two levels, then the refilled buffer hits
		fetch(32'h0040_0010, 34'h0_0020_0010, 1'b0, 16'h2);
		check("walk root addr", root_addr, {22'h100, 10'h001, 2'b00});
		fetch(32'h0040_0020, 34'h0_0020_0020, 1'b0, 16'h0);
		// Data buffer is separate: the same page walks again
		data(32'h0040_0044, 1'b0, 34'h0_0020_0044, 1'b0, 16'h2);
		data(32'h0040_0048, 1'b1, 34'h0_0020_0048, 1'b0, 16'h0);
		// Page without execute right, then an invalid page on the data side
		fetch(32'h0040_1000, 34'h0, 1'b1, 16'h2);
		data(32'h0040_2000, 1'b0, 34'h0, 1'b1, 16'h2);
		// A flush empties entries whatever the space id
		@(negedge clk);
		address_space_id = 9'h005;
		flush_tlb = 1'b1;
		@(negedge clk);
		flush_tlb = 1'b0;
		address_space_id = 9'h000;
		// Entries of the current space id are gone as well
		fetch(32'h0040_0010, 34'h0_0020_0010, 1'b0, 16'h2);
		race();
		// User mode may not use a page without the user bit
		user_mode = 1'b1;
		data(32'h0040_0048, 1'b0, 34'h0, 1'b1, 16'h0);
		end_of_test();
	end

	// Watchdog well beyond the expected run length
	initial begin
		#20000;
		error_cnt++;
		end_of_test();
	end
endmodule

`default_nettype wire

// file: prot_check.sv
// Physical protection checker over a table of address ranges
`default_nettype none

module prot_check #(
	parameter int ENTRIES = 8
) (
	input wire logic [mmu_pkg::PA_W-1:0] addr,
	input wire logic [2:0] acc,
	input wire logic machine,
	input wire logic [ENTRIES*mmu_pkg::PA_W-1:0] base,
	input wire logic [ENTRIES*mmu_pkg::PA_W-1:0] top,
	input wire logic [ENTRIES*3-1:0] perm,
	output logic ok
);
	localparam int GW = mmu_pkg::PA_W - mmu_pkg::PROT_SHIFT;

	logic [GW-1:0] granule;
	logic [GW-1:0] lo;
	logic [GW-1:0] hi;

	assign granule = addr[mmu_pkg::PA_W-1:mmu_pkg::PROT_SHIFT];

	// ------------------------------------------------------------
	// Lowest matching entry decides; no match passes machine only
	// ------------------------------------------------------------
	always_comb begin
		ok = machine;
		lo = '0;
		hi = '0;
		for (int i = ENTRIES - 1; i >= 0; i--) begin
			lo = base[i*mmu_pkg::PA_W+mmu_pkg::PROT_SHIFT +: GW];
			hi = top[i*mmu_pkg::PA_W+mmu_pkg::PROT_SHIFT +: GW];
			if (granule >= lo && granule < hi) begin
				ok = machine || ((perm[i*3 +: 3] & acc) == acc);
			end
		end
	end
endmodule

`default_nettype wire

// file: tlb_store.sv
// Fully associative flip-flop translation buffer
`default_nettype none

module tlb_store #(
	parameter int ENTRIES = 16,
	parameter int ADDRESS_SPACE_ID_W = 9
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic flush,
	input wire logic [mmu_pkg::VPN_W-1:0] lk_vpn,
	input wire logic [ADDRESS_SPACE_ID_W-1:0] lk_address_space_id,
	output logic hit,
	output logic [mmu_pkg::PPN_W-1:0] hit_ppn,
	output logic [mmu_pkg::PERM_N-1:0] hit_perm,
	input wire logic we,
	input wire logic [mmu_pkg::VPN_W-1:0] w_vpn,
	input wire logic w_super,
	input wire logic [mmu_pkg::PPN_W-1:0] w_ppn,
	input wire logic [mmu_pkg::PERM_N-1:0] w_perm,
	input wire logic [ADDRESS_SPACE_ID_W-1:0] w_address_space_id
);
	localparam int IDX_W = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;
	localparam int HI_W = mmu_pkg::VPN_W - mmu_pkg::VPN_PART_W;

	logic [ENTRIES-1:0] valid_reg;
	logic [ENTRIES-1:0] super_reg;
	logic [mmu_pkg::VPN_W-1:0] vpn_reg [ENTRIES];
	logic [mmu_pkg::PPN_W-1:0] ppn_reg [ENTRIES];
	logic [mmu_pkg::PERM_N-1:0] perm_reg [ENTRIES];
	logic [ADDRESS_SPACE_ID_W-1:0] address_space_id_reg [ENTRIES];
	logic [IDX_W-1:0] victim_reg;
	logic [ENTRIES-1:0] match;

	// ------------------------------------------------------------
	// Lookup: every entry compared at once, no register stage
	// ------------------------------------------------------------
	always_comb begin
		hit = 1'b0;
		hit_ppn = '0;
		hit_perm = '0;
		for (int i = 0; i < ENTRIES; i++) begin
			match[i] = valid_reg[i] && address_space_id_reg[i] == lk_address_space_id
				&& vpn_reg[i][mmu_pkg::VPN_W-1 -: HI_W] == lk_vpn[mmu_pkg::VPN_W-1 -: HI_W]
				&& (super_reg[i] || vpn_reg[i][mmu_pkg::VPN_PART_W-1:0]
				== lk_vpn[mmu_pkg::VPN_PART_W-1:0]);
			if (match[i]) begin
				hit = 1'b1;
				// Superpage entries take the low page number from the lookup
				hit_ppn = super_reg[i] ? {ppn_reg[i][mmu_pkg::PPN_W-1:mmu_pkg::VPN_PART_W],
					lk_vpn[mmu_pkg::VPN_PART_W-1:0]} : ppn_reg[i];
				hit_perm = perm_reg[i];
			end
		end
	end

	// Valid bits: flush drops every entry regardless of space id
	always_ff @(posedge clk) begin
		if (srst || flush) begin
			valid_reg <= '0;
			victim_reg <= '0;
		end else if (we) begin
			valid_reg[victim_reg] <= 1'b1;
			victim_reg <= (victim_reg == IDX_W'(ENTRIES - 1)) ? '0 : victim_reg + 1'b1;
		end
	end

	// Entry contents, replaced round robin
	always_ff @(posedge clk) begin
		if (we) begin
			vpn_reg[victim_reg] <= w_vpn;
			super_reg[victim_reg] <= w_super;
			ppn_reg[victim_reg] <= w_ppn;
			perm_reg[victim_reg] <= w_perm;
			address_space_id_reg[victim_reg] <= w_address_space_id;
		end
	end
endmodule

`default_nettype wire
